// *** cbt_bit_timing.sv ***
// CAN bit-timing registers, bit-segment sequencer with resync and sampling, and message-object page
//
// Summary of operation
// R1: Quantum period is controller clock times prescaler value plus one.
// R2: Jump width is the two-bit jump field plus one, in quanta.
// R3: Resynchronize on every relevant bus edge during the frame; the code acts only on the first falling edge of each bit.
// R4: A resync changes the bit period by at most the jump width.
// R5: Propagation segment lasts the three-bit propagation field plus one quanta.
// R6: Phase segment two lasts its three-bit field plus one quanta.
// R7: Phase segment one lasts its three-bit field plus one quanta.
// R8: Resync only shortens phase two and only lengthens phase one.
// R9: Software makes phase two the larger of phase one and two quanta.
// R10: Sample-mode one takes three samples half a quantum apart.
// R11: Three samples decide by majority; otherwise one sample at sample point.
// R12: Software writes timing registers only while the controller is disabled.
// R13: Page upper nibble selects the message object.
// R14: Page low three bits index the data byte; bit three stops auto-increment.
// R15: Auto-increment advances the index after each data access, wrapping seven to zero.
// R16: Page register clears to zero on reset.
// R17: Reserved timing bits read undefined and must be written zero.
`include "cbt_map.svh"
`default_nettype none
module cbt_bit_timing (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Special-function register access
  input wire cbt_pkg::cbt_sfr_s sfrReq,
  output logic [7:0] sfrRdData,
  // Message data register access strobe
  input wire logic msgDataAccess,
  // Controller configuration held elsewhere
  input wire logic [5:0] baudPrescaler,
  input wire logic controllerEnable,
  // Bus receive pin
  input wire logic canRx,
  // Bit timing results and message-object page fields
  output logic rxBit,
  output logic samplePoint,
  output logic bitStart,
  output cbt_pkg::cbt_timing_s timing,
  output cbt_pkg::cbt_page_s page
);

  function automatic logic [3:0] qlen(input logic [2:0] f);
    qlen = {1'b0, f} + `CBT_Q_ONE;
  endfunction

  function automatic logic [3:0] qmin(input logic [3:0] a, input logic [3:0] b);
    qmin = (a < b) ? a : b;
  endfunction

  // Register storage
  logic [7:0] bt2_ff;
  logic [7:0] bt3_ff;
  logic [7:0] page_ff;
  logic [7:0] rdData_ff;
  logic [7:0] nxt_bt2;
  logic [7:0] nxt_bt3;
  logic [7:0] nxt_page;
  logic [7:0] nxt_rdData;

  wire logic wrPage = sfrReq.wr && (sfrReq.addr == `CBT_ADDR_PAGE);
  wire logic wrBt2 = sfrReq.wr && (sfrReq.addr == `CBT_ADDR_BT2);
  wire logic wrBt3 = sfrReq.wr && (sfrReq.addr == `CBT_ADDR_BT3);
  wire logic incIdx = msgDataAccess && !page_ff[`CBT_INDEX_AUTOINC_DISABLE_B];
  wire logic [2:0] nxtIdx = page_ff[`CBT_DATA_BYTE_INDEX_F] + `CBT_IDX_STEP;
  wire logic [7:0] rdMux = (sfrReq.addr == `CBT_ADDR_PAGE) ? page_ff :
                           (sfrReq.addr == `CBT_ADDR_BT2) ? bt2_ff :
                           (sfrReq.addr == `CBT_ADDR_BT3) ? bt3_ff : 8'h00;

  // Reserved bits are not stored and read back as zero
  assign nxt_bt2 = wrBt2 ? (sfrReq.wdata & `CBT_BT2_MASK) : bt2_ff; // [R17]
  assign nxt_bt3 = wrBt3 ? (sfrReq.wdata & `CBT_BT3_MASK) : bt3_ff; // [R17]
  // Software write wins over an increment in the same cycle
  assign nxt_page = wrPage ? sfrReq.wdata :
                    incIdx ? {page_ff[7:3], nxtIdx} : page_ff; // [R14] [R15]
  assign nxt_rdData = sfrReq.rd ? rdMux : rdData_ff;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bt2_ff <= `CBT_BT_RST;
      bt3_ff <= `CBT_BT_RST;
      page_ff <= `CBT_PAGE_RST; // [R16]
      rdData_ff <= 8'h00;
    end else begin
      bt2_ff <= nxt_bt2;
      bt3_ff <= nxt_bt3;
      page_ff <= nxt_page;
      rdData_ff <= nxt_rdData;
    end
  end

  assign sfrRdData = rdData_ff;
  assign timing.jump_width_field = bt2_ff[`CBT_SJW_F];
  assign timing.propagation_segment_field = bt2_ff[`CBT_PRS_F];
  assign timing.phase_seg_two_field = bt3_ff[`CBT_PHASE_SEG_TWO_FIELD_F];
  assign timing.phase_seg_one_field = bt3_ff[`CBT_PHASE_SEG_ONE_FIELD_F];
  assign timing.triple_sample_select = bt3_ff[`CBT_SMP_B];
  assign page.objNum = page_ff[`CBT_OBJECT_NUMBER_FIELD_F]; // [R13]
  assign page.autoincDis = page_ff[`CBT_INDEX_AUTOINC_DISABLE_B];
  assign page.index = page_ff[`CBT_DATA_BYTE_INDEX_F]; // [R14]

  // Receive pin synchroniser; a level counts once stages two and three agree
  logic rxS1_ff;
  logic rxS2_ff;
  logic rxS3_ff;
  logic rxLvl_ff;
  wire logic rxAgree = (rxS2_ff == rxS3_ff);
  wire logic nxt_rxLvl = rxAgree ? rxS3_ff : rxLvl_ff;
  wire logic fallEdge = rxLvl_ff && rxAgree && !rxS3_ff;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxS1_ff <= 1'b1;
      rxS2_ff <= 1'b1;
      rxS3_ff <= 1'b1;
      rxLvl_ff <= 1'b1;
    end else begin
      rxS1_ff <= canRx;
      rxS2_ff <= rxS1_ff;
      rxS3_ff <= rxS2_ff;
      rxLvl_ff <= nxt_rxLvl;
    end
  end

  // Quantum prescaler and segment sequencer
  cbt_pkg::cbt_seg_e seg_ff;
  cbt_pkg::cbt_seg_e nxt_seg;
  logic [5:0] psc_ff;
  logic [5:0] nxt_psc;
  logic [3:0] tqCnt_ff;
  logic [3:0] nxt_tqCnt;
  logic [3:0] ext_ff;
  logic [3:0] nxt_ext;
  logic [3:0] shr_ff;
  logic [3:0] nxt_shr;
  logic resyncDone_ff;
  logic nxt_resyncDone;

  wire logic [3:0] sjwLen = {2'b00, timing.jump_width_field} + `CBT_Q_ONE; // [R2]
  wire logic [3:0] prsLen = qlen(timing.propagation_segment_field); // [R5]
  wire logic [3:0] ph1Len = qlen(timing.phase_seg_one_field) + ext_ff; // [R7] [R8]
  wire logic [3:0] ph2Len = qlen(timing.phase_seg_two_field) - shr_ff; // [R6] [R8]
  wire logic tqTick = controllerEnable && (psc_ff == baudPrescaler); // [R1]
  wire logic [3:0] segLen = (seg_ff == cbt_pkg::SEG_SYNC) ? `CBT_SYNC_TQ :
                            (seg_ff == cbt_pkg::SEG_PROP) ? prsLen :
                            (seg_ff == cbt_pkg::SEG_PH1) ? ph1Len : ph2Len;
  // A shrink that lands with a quantum tick must still end phase two, not run on to wrap
  wire logic lastQ = (tqCnt_ff >= (segLen - `CBT_Q_ONE));
  wire logic segDone = tqTick && lastQ;
  wire logic edgeOk = fallEdge && controllerEnable && !resyncDone_ff; // [R3]
  wire logic lateEdge = edgeOk && ((seg_ff == cbt_pkg::SEG_PROP) || (seg_ff == cbt_pkg::SEG_PH1));
  wire logic earlyEdge = edgeOk && (seg_ff == cbt_pkg::SEG_PH2);
  // Error may reach sixteen quanta late in a long phase one; saturate rather than wrap to zero
  wire logic [4:0] lateErrW = (seg_ff == cbt_pkg::SEG_PROP) ? ({1'b0, tqCnt_ff} + `CBT_ERR_ONE) :
                              ({1'b0, prsLen} + {1'b0, tqCnt_ff} + `CBT_ERR_ONE);
  wire logic [3:0] lateErr = lateErrW[4] ? `CBT_Q_MAX : lateErrW[3:0];
  wire logic [3:0] ph2Left = ph2Len - tqCnt_ff;
  wire logic jumpSync = earlyEdge && (ph2Left <= sjwLen); // [R4] [R8]
  wire logic shrink = earlyEdge && !jumpSync;

  always_comb begin
    nxt_seg = seg_ff;
    nxt_tqCnt = tqCnt_ff;
    nxt_ext = lateEdge ? qmin(lateErr, sjwLen) : ext_ff; // [R4] [R8]
    nxt_shr = shrink ? sjwLen : shr_ff; // [R4] [R8]
    nxt_resyncDone = resyncDone_ff || edgeOk;
    if (!controllerEnable) begin
      nxt_seg = cbt_pkg::SEG_SYNC;
      nxt_tqCnt = `CBT_Q_ZERO;
      nxt_ext = `CBT_Q_ZERO;
      nxt_shr = `CBT_Q_ZERO;
      nxt_resyncDone = 1'b0;
    end else if (jumpSync) begin
      // Edge stands in for the sync segment of the next bit
      nxt_seg = cbt_pkg::SEG_PROP;
      nxt_tqCnt = `CBT_Q_ZERO;
      nxt_ext = `CBT_Q_ZERO;
      nxt_shr = `CBT_Q_ZERO;
      nxt_resyncDone = 1'b1;
    end else if (segDone) begin
      nxt_tqCnt = `CBT_Q_ZERO;
      unique case (seg_ff)
        cbt_pkg::SEG_SYNC: nxt_seg = cbt_pkg::SEG_PROP;
        cbt_pkg::SEG_PROP: nxt_seg = cbt_pkg::SEG_PH1;
        cbt_pkg::SEG_PH1: nxt_seg = cbt_pkg::SEG_PH2;
        cbt_pkg::SEG_PH2: begin
          nxt_seg = cbt_pkg::SEG_SYNC;
          nxt_ext = `CBT_Q_ZERO;
          nxt_shr = `CBT_Q_ZERO;
          nxt_resyncDone = 1'b0;
        end
      endcase
    end else if (tqTick) begin
      nxt_tqCnt = tqCnt_ff + `CBT_Q_ONE;
    end
  end

  assign nxt_psc = (!controllerEnable || jumpSync || tqTick) ? `CBT_PSC_ZERO : psc_ff + 6'h01; // [R1]

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seg_ff <= cbt_pkg::SEG_SYNC;
      psc_ff <= `CBT_PSC_ZERO;
      tqCnt_ff <= `CBT_Q_ZERO;
      ext_ff <= `CBT_Q_ZERO;
      shr_ff <= `CBT_Q_ZERO;
      resyncDone_ff <= 1'b0;
    end else begin
      seg_ff <= nxt_seg;
      psc_ff <= nxt_psc;
      tqCnt_ff <= nxt_tqCnt;
      ext_ff <= nxt_ext;
      shr_ff <= nxt_shr;
      resyncDone_ff <= nxt_resyncDone;
    end
  end

  // Sampling in the last quantum of phase one
  logic samp0_ff;
  logic samp1_ff;
  logic rxBit_ff;
  logic bitStart_ff;
  wire logic inLastPh1 = controllerEnable && (seg_ff == cbt_pkg::SEG_PH1) && lastQ;
  wire logic [5:0] halfIdx = {1'b0, baudPrescaler[5:1]};
  wire logic takeS0 = inLastPh1 && (psc_ff == `CBT_PSC_ZERO); // [R10]
  wire logic takeS1 = inLastPh1 && (psc_ff == halfIdx); // [R10]
  wire logic majority = (samp0_ff & samp1_ff) | (samp0_ff & rxLvl_ff) | (samp1_ff & rxLvl_ff);
  wire logic bitValue = timing.triple_sample_select ? majority : rxLvl_ff; // [R11]
  assign samplePoint = inLastPh1 && tqTick;
  wire logic nxt_bitStart = (segDone && (seg_ff == cbt_pkg::SEG_PH2) && !jumpSync) || jumpSync;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      samp0_ff <= 1'b1;
      samp1_ff <= 1'b1;
      rxBit_ff <= 1'b1;
      bitStart_ff <= 1'b0;
    end else begin
      samp0_ff <= takeS0 ? rxLvl_ff : samp0_ff;
      samp1_ff <= takeS1 ? rxLvl_ff : samp1_ff;
      rxBit_ff <= samplePoint ? bitValue : rxBit_ff; // [R11]
      bitStart_ff <= controllerEnable && nxt_bitStart;
    end
  end

  assign rxBit = rxBit_ff;
  assign bitStart = bitStart_ff;

  default clocking cbtClk @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_quantum_restart: assert property (tqTick && !jumpSync |=> psc_ff == `CBT_PSC_ZERO) // [R1]
    else $error("prescaler did not restart after a quantum");
  a_jump_bound: assert property (lateEdge |=> ext_ff <= {2'b00, $past(timing.jump_width_field)} + `CBT_Q_ONE) // [R2]
    else $error("phase one lengthened beyond jump width");
  a_resync_late: assert property (controllerEnable && lateEdge |=> ext_ff != `CBT_Q_ZERO) // [R3]
    else $error("late edge did not lengthen phase one");
  a_shrink_bound: assert property (shrink |=> shr_ff == {2'b00, $past(timing.jump_width_field)} + `CBT_Q_ONE) // [R4]
    else $error("phase two shortened by other than jump width");
  a_prop_length: assert property (seg_ff == cbt_pkg::SEG_PROP && segDone |-> tqCnt_ff == {1'b0, timing.propagation_segment_field}) // [R5]
    else $error("propagation segment length wrong");
  a_ph2_length: assert property (seg_ff == cbt_pkg::SEG_PH2 && segDone && shr_ff == `CBT_Q_ZERO
    |-> tqCnt_ff == {1'b0, timing.phase_seg_two_field}) // [R6]
    else $error("phase two length wrong");
  a_ph1_length: assert property (seg_ff == cbt_pkg::SEG_PH1 && segDone && ext_ff == `CBT_Q_ZERO
    |-> tqCnt_ff == {1'b0, timing.phase_seg_one_field}) // [R7]
    else $error("phase one length wrong");
  a_ext_cause: assert property (ext_ff != `CBT_Q_ZERO && $changed(ext_ff) |-> $past(lateEdge)) // [R8]
    else $error("phase one lengthened without a late edge");
  a_single_sample: assert property (samplePoint && !timing.triple_sample_select |=> rxBit_ff == $past(rxLvl_ff)) // [R11]
    else $error("single sample mode took wrong value");
  a_triple_sample: assert property (samplePoint && timing.triple_sample_select && samp0_ff && samp1_ff |=> rxBit_ff) // [R11]
    else $error("majority of samples ignored");
  a_page_write: assert property (wrPage |=> page_ff == $past(sfrReq.wdata)) // [R13]
    else $error("page write not taken");
  a_index_step: assert property (msgDataAccess && !page_ff[`CBT_INDEX_AUTOINC_DISABLE_B] && !wrPage
    |=> page_ff[`CBT_DATA_BYTE_INDEX_F] == $past(page_ff[`CBT_DATA_BYTE_INDEX_F]) + `CBT_IDX_STEP) // [R15]
    else $error("index did not advance");
  a_index_hold: assert property (msgDataAccess && page_ff[`CBT_INDEX_AUTOINC_DISABLE_B] && !wrPage |=> $stable(page_ff)) // [R14]
    else $error("index moved with auto-increment off");
  a_reserved_zero: assert property ((bt2_ff & ~`CBT_BT2_MASK) == 8'h00 && (bt3_ff & ~`CBT_BT3_MASK) == 8'h00) // [R17]
    else $error("reserved timing bits stored");

endmodule // cbt_bit_timing
`default_nettype wire

// *** cbt_map.svh ***
// Register addresses, field positions and reset values of the CAN bit-timing and page block
`ifndef CBT_MAP_SVH
`define CBT_MAP_SVH
`define CBT_ADDR_PAGE 8'hb1
`define CBT_ADDR_BT2 8'hb5
`define CBT_ADDR_BT3 8'hb6
`define CBT_PAGE_RST 8'h00
`define CBT_BT_RST 8'h00
`define CBT_BT2_MASK 8'h6e
`define CBT_BT3_MASK 8'h7f
`define CBT_SJW_F 6:5
`define CBT_PRS_F 3:1
`define CBT_PHASE_SEG_TWO_FIELD_F 6:4
`define CBT_PHASE_SEG_ONE_FIELD_F 3:1
`define CBT_SMP_B 0
`define CBT_OBJECT_NUMBER_FIELD_F 7:4
`define CBT_INDEX_AUTOINC_DISABLE_B 3
`define CBT_DATA_BYTE_INDEX_F 2:0
`define CBT_SYNC_TQ 4'h1
`define CBT_IPT_TQ 4'h2
`define CBT_IDX_STEP 3'h1
`define CBT_Q_ONE 4'h1
`define CBT_PSC_ZERO 6'h00
`define CBT_Q_ZERO 4'h0
`define CBT_Q_MAX 4'hf
`define CBT_ERR_ONE 5'h01
`endif

// *** cbt_pkg.sv ***
// Types shared by the CAN bit-timing and page block
`default_nettype none
package cbt_pkg;
  typedef enum {SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2} cbt_seg_e;
  typedef struct packed {
    logic [1:0] jump_width_field;
    logic [2:0] propagation_segment_field;
    logic [2:0] phase_seg_two_field;
    logic [2:0] phase_seg_one_field;
    logic triple_sample_select;
  } cbt_timing_s;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cbt_sfr_s;
  typedef struct packed {
    logic [3:0] objNum;
    logic autoincDis;
    logic [2:0] index;
  } cbt_page_s;
endpackage
`default_nettype wire

// *** cbt_can_node.sv ***
// Behavioural CAN node that drives the receive line of the block
`default_nettype none
module cbt_can_node (
  // Bus line
  output var logic canRx
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus sits recessive, the pull-up level
  initial canRx = 1'b1;
  // Drives a level; a falling edge off the bit grid is a phase error
  task automatic drive(input logic lvl);
    canRx = lvl;
  endtask
endmodule // cbt_can_node
`default_nettype wire

// *** tb.sv ***
// Testbench for the CAN bit-timing and page block
`include "cbt_map.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  cbt_pkg::cbt_sfr_s sfrReq = '0;
  logic msgDataAccess = 1'b0;
  logic [5:0] baudPrescaler = 6'h01;
  logic controllerEnable = 1'b0;
  wire logic canRx;
  logic [7:0] sfrRdData;
  logic rxBit;
  logic samplePoint;
  logic bitStart;
  cbt_pkg::cbt_timing_s timing;
  cbt_pkg::cbt_page_s page;
  int num_errors = 0;
  int compares = 0;
  logic [7:0] rv;
  int n;
  int sp;
  int sjwT[4] = '{0, 0, 1, 0};
  int offT[4] = '{0, 4, 4, 9};
  int smpT[4] = '{0, 0, 1, 0};
  int perT[4] = '{18, 20, 22, 16};
  int spT[4] = '{11, 13, 15, 11};
  always #12.5 clk = ~clk;
  cbt_can_node node_u (.canRx(canRx));
  cbt_bit_timing dut_u (.clk(clk), .sys_rst(sys_rst), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
    .msgDataAccess(msgDataAccess), .baudPrescaler(baudPrescaler), .controllerEnable(controllerEnable),
    .canRx(canRx), .rxBit(rxBit), .samplePoint(samplePoint), .bitStart(bitStart), .timing(timing),
    .page(page));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfrReq = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge clk);
    sfrReq.wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfrReq = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge clk);
    d = sfrRdData;
    sfrReq.rd = 1'b0;
    @(negedge clk);
  endtask
  // Counts clocks to the next bit start, optionally driving the line on the way
  task automatic bit_run(input bit doChk, input int off, input logic lvl, input int expN, input int expSp);
    sp = 0;
    for (n = 1; n < 200; n++) begin
      @(negedge clk);
      if (n == off) node_u.drive(lvl);
      if (samplePoint === 1'b1 && sp == 0) sp = n;
      if (bitStart === 1'b1) break;
    end
    // A bit that never ends counts as a mismatch; the run still reaches the report
    if (n >= 200) begin
      num_errors++;
    end
    if (doChk) begin
      chk(n, expN);
      chk(sp, expSp);
    end
  endtask
  initial begin
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    chk(page, `CBT_PAGE_RST);
    rd(`CBT_ADDR_PAGE, rv);
    chk(rv, `CBT_PAGE_RST);
    // Timing registers read back every field bit; reserved bits are written as zero
    wr(`CBT_ADDR_BT2, 8'h6e);
    rd(`CBT_ADDR_BT2, rv);
    chk(rv, 8'h6e);
    wr(`CBT_ADDR_BT3, 8'h7f);
    rd(`CBT_ADDR_BT3, rv);
    chk(rv, 8'h7f);
    chk(timing, 12'hfff);
    rd(8'hb4, rv);
    chk(rv, 8'h00);
    // Two back-to-back data accesses wrap the index from six through seven to zero
    wr(`CBT_ADDR_PAGE, 8'h36);
    msgDataAccess = 1'b1;
    repeat (2) @(negedge clk);
    msgDataAccess = 1'b0;
    chk(page, 8'h30);
    rd(`CBT_ADDR_PAGE, rv);
    chk(rv, 8'h30);
    wr(`CBT_ADDR_PAGE, 8'hbf);
    msgDataAccess = 1'b1;
    @(negedge clk);
    msgDataAccess = 1'b0;
    chk(page, 8'hbf);
    // Reset in mid-run clears a written page
    sys_rst = 1'b1;
    @(negedge clk);
    sys_rst = 1'b0;
    chk(page, `CBT_PAGE_RST);
    // Bit timing: quantum 2 clocks, prop 2, ph1 3, ph2 3 quanta, phase two kept at least ph1 and 2 quanta
    for (int i = 0; i < 4; i++) begin
      controllerEnable = 1'b0;
      node_u.drive(1'b1);
      wr(`CBT_ADDR_BT2, {1'b0, 2'(sjwT[i]), 1'b0, 3'h1, 1'b0});
      wr(`CBT_ADDR_BT3, {1'b0, 3'h2, 3'h2, 1'(smpT[i])});
      chk(timing, {2'(sjwT[i]), 3'h1, 3'h2, 3'h2, 1'(smpT[i])});
      controllerEnable = 1'b1;
      bit_run(1'b0, 0, 1'b1, 0, 0);
      bit_run(1'b1, offT[i], 1'b0, perT[i], spT[i]);
      bit_run(1'b1, 0, 1'b0, 18, 11);
      chk(rxBit, offT[i] == 0);
      // Line rises between the early samples and the sample point: majority keeps it low
      bit_run(1'b1, 7, 1'b1, 18, 11);
      chk(rxBit, smpT[i] == 0);
    end
    controllerEnable = 1'b0;
    node_u.drive(1'b1);
    close_out();
  end
endmodule // tb
`default_nettype wire
